// ==== src/esf_event_status_flags.sv ====
// Sticky event status flags with clear-on-read and a backup copy.
// Assumes all inputs synchronous to clock; the host port issues single-cycle
// read requests and takes the answer one cycle later.
//
// Operation
// (RL1) Flags 0..3 set on rising edge of the four meter pulses, sticky.
// (RL2) Flag 4 sets when fresh accumulation data becomes available.
// (RL3) Flag 5 sets when the compute engine finishes a code pass.
// (RL4) Flag 7 sets whenever the two-bit supply status changes.
// (RL5) Flag 8 sets after reset; status reads 0x0100_0100 after reset.
// (RL6) Event flags clear automatically once the host reads the main status.
// (RL7) Bits 0..5 mirror to 16..21, bit 8 to 24; reserved read zero.
// (RL8) Each main status read loads the backup register with its contents.
// (RL9) Host compares backup and main; both stay readable.
// (RL10) Backup is read-only, resets to zero, same flag layout as main; the code masks supply bit 7 out of the backup.
// (RL11) An event coinciding with the read clear keeps its flag set.
// (RL12) Supply status is a two-bit good, low or failed code.
`timescale 1ns/1ps
`default_nettype none
`include "esf_map.svh"

module esf_event_status_flags #(
  parameter int PULSE_COUNT = `ESF_PULSE_COUNT
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [PULSE_COUNT-1:0] meter_pulse,
  input wire logic fresh_data,
  input wire logic engine_pass_done,
  input wire logic [`ESF_SUPPLY_WIDTH-1:0] system_supply,
  input wire esf_pkg::esf_rd_req_type rd_req,
  output var esf_pkg::esf_rd_rsp_type rd_rsp
);

  // ----------------------------------------
  // Pulse start detection
  // ----------------------------------------
  logic [PULSE_COUNT-1:0] pulse_prev;
  logic [PULSE_COUNT-1:0] next_pulse_prev;
  logic [PULSE_COUNT-1:0] pulse_start;

  genvar gi;
  generate
    for (gi = 0; gi < PULSE_COUNT; gi = gi + 1)
    begin : g_pulse
      // Level history, so a long pulse sets its flag only once
      assign pulse_start[gi] = meter_pulse[gi] & ~pulse_prev[gi]; // [RL1]
    end
  endgenerate

  always_comb
  begin
    next_pulse_prev = meter_pulse;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pulse_prev <= '0;
    end
    else
    begin
      pulse_prev <= next_pulse_prev;
    end
  end

  // ----------------------------------------
  // Supply status change detection
  // ----------------------------------------
  esf_pkg::esf_supply_type supply_prev;
  esf_pkg::esf_supply_type next_supply_prev;
  logic supply_changed;

  // Reset value assumes supply good; a low supply at start reports a change
  assign supply_changed = (system_supply != supply_prev); // [RL4] [RL12]

  always_comb
  begin
    next_supply_prev = esf_pkg::esf_supply_type'(system_supply);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      supply_prev <= esf_pkg::esf_supply_type'(`ESF_SUPPLY_RESET);
    end
    else
    begin
      supply_prev <= next_supply_prev;
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  logic read_status;
  logic read_backup;

  assign read_status = rd_req.en && (rd_req.addr == `ESF_EVENT_STATUS_OFFSET);
  assign read_backup = rd_req.en && (rd_req.addr == `ESF_EVENT_STATUS_BACKUP_OFFSET);

  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  esf_pkg::esf_flags_type flags;
  esf_pkg::esf_flags_type next_flags;
  esf_pkg::esf_flags_type flag_set;
  logic [31:0] status_view;

  always_comb
  begin
    flag_set = '0;
    flag_set.real_pulse_flag = pulse_start[`ESF_REAL_PULSE_BIT]; // [RL1]
    flag_set.reactive_pulse_flag = pulse_start[`ESF_REACTIVE_PULSE_BIT]; // [RL1]
    flag_set.aux_x_pulse_flag = pulse_start[`ESF_AUX_X_PULSE_BIT]; // [RL1]
    flag_set.aux_y_pulse_flag = pulse_start[`ESF_AUX_Y_PULSE_BIT]; // [RL1]
    flag_set.fresh_data_flag = fresh_data; // [RL2]
    flag_set.engine_pass_done_flag = engine_pass_done; // [RL3]
    flag_set.supply_change_flag = supply_changed; // [RL4]
    flag_set.reset_seen_flag = 1'b0;
  end

  always_comb
  begin
    next_flags = flags;
    if (read_status)
    begin
      // Clear first, then new events, so nothing arriving now is lost
      next_flags = '0; // [RL6]
    end
    next_flags = next_flags | flag_set; // [RL11]
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      flags <= '0;
      flags.reset_seen_flag <= 1'b1; // [RL5]
    end
    else
    begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------
  // Main status layout with mirrored copies
  // ----------------------------------------
  always_comb
  begin
    status_view = 32'h0000_0000;
    status_view[`ESF_REAL_PULSE_BIT] = flags.real_pulse_flag;
    status_view[`ESF_REACTIVE_PULSE_BIT] = flags.reactive_pulse_flag;
    status_view[`ESF_AUX_X_PULSE_BIT] = flags.aux_x_pulse_flag;
    status_view[`ESF_AUX_Y_PULSE_BIT] = flags.aux_y_pulse_flag;
    status_view[`ESF_FRESH_DATA_BIT] = flags.fresh_data_flag;
    status_view[`ESF_ENGINE_PASS_DONE_BIT] = flags.engine_pass_done_flag;
    status_view[`ESF_SUPPLY_CHANGE_BIT] = flags.supply_change_flag;
    status_view[`ESF_RESET_SEEN_BIT] = flags.reset_seen_flag;
    status_view[`ESF_MIRROR_LOW_BASE +: `ESF_MIRROR_LOW_COUNT] =
      status_view[`ESF_MIRROR_LOW_COUNT-1:0]; // [RL7]
    status_view[`ESF_MIRROR_RESET_BIT] = flags.reset_seen_flag; // [RL7]
  end

  // ----------------------------------------
  // Backup register
  // ----------------------------------------
  logic [31:0] backup;
  logic [31:0] next_backup;

  always_comb
  begin
    next_backup = backup;
    if (read_status)
    begin
      // Supply bit has no place in the backup layout
      next_backup = status_view & `ESF_BACKUP_MASK; // [RL8] [RL10]
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      backup <= `ESF_EVENT_STATUS_BACKUP_RESET; // [RL10]
    end
    else
    begin
      backup <= next_backup;
    end
  end

  // ----------------------------------------
  // Read answer
  // ----------------------------------------
  esf_pkg::esf_rd_rsp_type next_rd_rsp;

  always_comb
  begin
    next_rd_rsp.valid = rd_req.en;
    next_rd_rsp.data = 32'h0000_0000;
    if (read_status)
    begin
      // Answer shows flags before this read's clear
      next_rd_rsp.data = status_view; // [RL9]
    end
    else if (read_backup)
    begin
      // Backup answers its value before any update
      next_rd_rsp.data = backup; // [RL9] [RL10]
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rd_rsp <= '0;
    end
    else
    begin
      rd_rsp <= next_rd_rsp;
    end
  end

endmodule

`default_nettype wire

// ==== src/esf_map.svh ====
// Offsets, field positions and reset values of the event status flags.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ESF_MAP_SVH
`define ESF_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ESF_EVENT_STATUS_OFFSET 12'h0310
`define ESF_EVENT_STATUS_BACKUP_OFFSET 12'h0311

// ----------------------------------------
// Flag positions in the low half
// ----------------------------------------
`define ESF_REAL_PULSE_BIT 0
`define ESF_REACTIVE_PULSE_BIT 1
`define ESF_AUX_X_PULSE_BIT 2
`define ESF_AUX_Y_PULSE_BIT 3
`define ESF_FRESH_DATA_BIT 4
`define ESF_ENGINE_PASS_DONE_BIT 5
`define ESF_SUPPLY_CHANGE_BIT 7
`define ESF_RESET_SEEN_BIT 8

// ----------------------------------------
// Mirror positions and widths
// ----------------------------------------
`define ESF_PULSE_COUNT 4
`define ESF_MIRROR_LOW_BASE 16
`define ESF_MIRROR_LOW_COUNT 6
`define ESF_MIRROR_RESET_BIT 24
`define ESF_SUPPLY_WIDTH 2

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define ESF_EVENT_STATUS_RESET 32'h0100_0100
`define ESF_EVENT_STATUS_BACKUP_RESET 32'h0000_0000
`define ESF_BACKUP_MASK 32'h013F_013F
`define ESF_SUPPLY_RESET 2'h0

`endif

// ==== src/esf_pkg.sv ====
// Types shared by the event status flags block.
// Assumes esf_map.svh is on the include path.
`include "esf_map.svh"

package esf_pkg;

  // ----------------------------------------
  // Supply status codes
  // ----------------------------------------
  typedef enum logic [`ESF_SUPPLY_WIDTH-1:0] {
    ESF_SUPPLY_GOOD = 2'h0,
    ESF_SUPPLY_LOW = 2'h1,
    ESF_SUPPLY_FAILED = 2'h3
  } esf_supply_type;

  // ----------------------------------------
  // Host read request and answer
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic [11:0] addr;
  } esf_rd_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } esf_rd_rsp_type;

  // ----------------------------------------
  // Sticky flags held by the block
  // ----------------------------------------
  typedef struct packed {
    logic reset_seen_flag;
    logic supply_change_flag;
    logic engine_pass_done_flag;
    logic fresh_data_flag;
    logic aux_y_pulse_flag;
    logic aux_x_pulse_flag;
    logic reactive_pulse_flag;
    logic real_pulse_flag;
  } esf_flags_type;

endpackage

// ==== test/esf_event_status_flags_props.sv ====
// Checker of the status port against its event inputs.
// Assumes it is bound onto the block.
`timescale 1ns/1ps
`default_nettype none
module esf_event_status_flags_props #(
  parameter int PULSE_COUNT = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [PULSE_COUNT-1:0] meter_pulse,
  input wire logic fresh_data,
  input wire logic engine_pass_done,
  input wire logic [1:0] system_supply,
  input wire esf_pkg::esf_rd_req_type rd_req,
  input wire esf_pkg::esf_rd_rsp_type rd_rsp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic mrd;
  logic brd;
  logic [31:0] dat;
  assign mrd = rd_req.en && rd_req.addr == 12'h0310;
  assign brd = rd_req.en && rd_req.addr == 12'h0311;
  assign dat = rd_rsp.data;
  property p_ans; rd_req.en |=> rd_rsp.valid; endproperty
  property p_idle; !rd_req.en |=> rd_rsp == '0; endproperty
  property p_pls; $rose(meter_pulse[0]) ##1 mrd |=> dat[0] && dat[16]; endproperty
  property p_frs; fresh_data ##1 mrd |=> dat[4]; endproperty
  property p_eng; engine_pass_done ##1 mrd |=> dat[5]; endproperty
  property p_sup; !$stable(system_supply) ##1 mrd |=> dat[7]; endproperty
  // Quiet cycle: nothing may survive the clear
  property p_clr; mrd && !fresh_data && !engine_pass_done && $stable(meter_pulse)
    && $stable(system_supply) ##1 mrd |=> dat == 32'h0000_0000; endproperty
  property p_mir; rd_rsp.valid |-> dat[21:16] == dat[5:0] && dat[24] == dat[8]
    && (dat & 32'hFEC0_FE40) == 32'h0000_0000; endproperty
  property p_bak; mrd ##1 brd |=> dat == ($past(dat) & 32'h013F_013F); endproperty
  property p_keep; mrd && engine_pass_done ##1 mrd |=> dat[5]; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  a_idle: assert property (p_idle) else $error("answer without read");
  a_pls: assert property (p_pls) else $error("pulse flag missing");
  a_frs: assert property (p_frs) else $error("data flag missing");
  a_eng: assert property (p_eng) else $error("engine flag missing");
  a_sup: assert property (p_sup) else $error("supply flag missing");
  a_clr: assert property (p_clr) else $error("flags not cleared");
  a_mir: assert property (p_mir) else $error("bad layout");
  a_bak: assert property (p_bak) else $error("backup wrong");
  a_keep: assert property (p_keep) else $error("event lost in clear");
  c_clr: cover property (p_clr);
  c_bak: cover property (p_bak);
  c_keep: cover property (p_keep);
endmodule
bind esf_event_status_flags esf_event_status_flags_props #(.PULSE_COUNT(PULSE_COUNT)) u_props (.clock(clock),
  .sys_rst(sys_rst), .meter_pulse(meter_pulse), .fresh_data(fresh_data), .engine_pass_done(engine_pass_done),
  .system_supply(system_supply), .rd_req(rd_req), .rd_rsp(rd_rsp));
`default_nettype wire

// ==== test/esf_host_model.sv ====
// Host controller model reading the status port.
// Assumes the one-cycle answer latency of the block.
`timescale 1ns/1ps
`default_nettype none
module esf_host_model (
  input wire logic clock,
  output var esf_pkg::esf_rd_req_type rd_req,
  input wire esf_pkg::esf_rd_rsp_type rd_rsp
);
  initial rd_req = '0;
  // Two back-to-back strobes; each answer stands one cycle only
  task automatic read2(input logic [11:0] a0, input logic [11:0] a1,
    output logic [31:0] d0, output logic [31:0] d1, output logic ok);
    @(posedge clock);
    rd_req <= '{en: 1'b1, addr: a0};
    @(posedge clock);
    rd_req <= '{en: 1'b1, addr: a1};
    // Answer to a0 was launched at the previous edge and still stands here
    @(posedge clock);
    ok = rd_rsp.valid;
    d0 = rd_rsp.data;
    rd_req <= '0;
    @(posedge clock);
    ok = ok & rd_rsp.valid;
    d1 = rd_rsp.data;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_event_status_flags.sv ====
// Self-checking bench of the event status flags.
// Assumes the host model for all reads.
`timescale 1ns/1ps
`default_nettype none
module tb_event_status_flags;
  logic clock;
  logic sys_rst;
  logic [3:0] meter_pulse;
  logic fresh_data;
  logic engine_pass_done;
  logic [1:0] system_supply;
  esf_pkg::esf_rd_req_type rd_req;
  esf_pkg::esf_rd_rsp_type rd_rsp;
  logic [31:0] d0;
  logic [31:0] d1;
  int error_cnt = 0;
  int cmp_count = 0;
  esf_event_status_flags #(.PULSE_COUNT(4)) DUT (.clock(clock), .sys_rst(sys_rst), .meter_pulse(meter_pulse),
    .fresh_data(fresh_data), .engine_pass_done(engine_pass_done), .system_supply(system_supply),
    .rd_req(rd_req), .rd_rsp(rd_rsp));
  esf_host_model host (.clock(clock), .rd_req(rd_req), .rd_rsp(rd_rsp));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd(input logic [11:0] a0, input logic [11:0] a1);
    logic ok;
    host.read2(a0, a1, d0, d1, ok);
    check("valid", 32'h0000_0001, {31'h0, ok});
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic s_reset;
    rd(12'h0311, 12'h0000);
    check("backup", 32'h0000_0000, d0);
    check("unmapped", 32'h0000_0000, d1);
    rd(12'h0310, 12'h0311);
    check("status", 32'h0100_0100, d0);
    check("backup", 32'h0100_0100, d1);
  endtask
  task automatic s_events;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clock);
      meter_pulse <= (i < 4) ? 4'(1 << i) : 4'h0;
      fresh_data <= (i == 4);
      engine_pass_done <= (i == 5);
      // Read follows at once, so event and read lie one cycle apart
      fork
        rd(12'h0310, 12'h0310);
        begin
          @(posedge clock);
          meter_pulse <= 4'h0;
          fresh_data <= 1'b0;
          engine_pass_done <= 1'b0;
        end
      join
      check("event", 32'h0001_0001 << i, d0);
      check("cleared", 32'h0000_0000, d1);
    end
  endtask
  task automatic s_supply;
    esf_pkg::esf_supply_type codes [3] = '{esf_pkg::ESF_SUPPLY_LOW, esf_pkg::ESF_SUPPLY_FAILED,
      esf_pkg::ESF_SUPPLY_GOOD};
    foreach (codes[i])
    begin
      @(posedge clock);
      system_supply <= codes[i];
      rd(12'h0310, 12'h0311);
      check("supply", 32'h0000_0080, d0);
      check("backup", 32'h0000_0000, d1);
    end
  endtask
  task automatic s_collide;
    fork
      rd(12'h0310, 12'h0310);
      begin
        @(posedge clock);
        engine_pass_done <= 1'b1;
        @(posedge clock);
        engine_pass_done <= 1'b0;
      end
    join
    check("pre-clear", 32'h0000_0000, d0);
    check("set wins", 32'h0020_0020, d1);
  endtask
  task automatic s_rereset;
    // Mid-run reset with an event pending; reset must win and rearm bit 8
    @(posedge clock);
    sys_rst <= 1'b1;
    engine_pass_done <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    engine_pass_done <= 1'b0;
    rd(12'h0311, 12'h0310);
    check("backup", 32'h0000_0000, d0);
    check("status", 32'h0100_0100, d1);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    meter_pulse = 4'h0;
    fresh_data = 1'b0;
    engine_pass_done = 1'b0;
    system_supply = 2'h0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    s_reset();
    s_events();
    s_supply();
    s_collide();
    s_rereset();
    tally_and_finish();
  end
  // Hang guard
  initial
  begin
    repeat (2000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
